// ---- rtl/rst_pkg.sv ----
/*
 * Constants for the reset-cause and regulator-mode block: register
 * indices, field positions, reset values, timing counts and state codes.
 * Assumes a 100 MHz system clock.
 */
package rst_pkg;

	// ------------------------------------------------------------------
	// Clock and bus geometry
	// ------------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned ADDR_W  = 10;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CAUSE   = 8'hdf;
	localparam logic [7:0] IDX_REGMODE = 8'hfa;
	localparam logic [7:0] IDX_CFG     = 8'h20;
	localparam logic [7:0] IDX_BOOTVEC = 8'h21;
	localparam logic [7:0] IDX_STATUS  = 8'h22;

	localparam logic [ADDR_W-1:0] ADR_CAUSE   = {IDX_CAUSE, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_REGMODE = {IDX_REGMODE, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_CFG     = {IDX_CFG, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_BOOTVEC = {IDX_BOOTVEC, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_STATUS  = {IDX_STATUS, 2'b00};

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int unsigned HS_READY_BIT  = 0;
	localparam int unsigned LOW_CUR_BIT   = 7;

	localparam int unsigned EX_BIT   = 0;
	localparam int unsigned SF_BIT   = 1;
	localparam int unsigned WD_BIT   = 2;
	localparam int unsigned BK_BIT   = 3;
	localparam int unsigned POF_BIT  = 4;
	localparam int unsigned BOF_BIT  = 5;
	localparam int unsigned BROWNOUT_IRQ_FLAG_BIT = 6;

	localparam int unsigned CFG_RPE_BIT   = 0;
	localparam int unsigned CFG_BRK_BIT   = 1;
	localparam int unsigned CFG_WD_BIT    = 2;
	localparam int unsigned CFG_BOI_BIT   = 3;
	localparam int unsigned CFG_BOOT_BIT  = 4;
	localparam int unsigned CFG_ISP_BIT   = 5;

	// ------------------------------------------------------------------
	// Reset values and masks
	// ------------------------------------------------------------------
	localparam logic [7:0]  CAUSE_MASK   = 8'h7f;
	localparam logic [7:0]  CAUSE_POR    = 8'h30;
	localparam logic [7:0]  CFG_MASK     = 8'h3f;
	localparam logic [7:0]  CFG_RST      = 8'h01;
	localparam logic [7:0]  BOOTVEC_RST  = 8'h1f;
	localparam logic [7:0]  BOOT_LOW     = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned POR_HOLD_NS  = 1000;
	localparam int unsigned RST_PULSE_NS = 200;
	localparam int unsigned HS_SWITCH_NS = 500;
	localparam logic [7:0] POR_CYC   = 8'((POR_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] PULSE_CYC = 8'((RST_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] HS_CYC    = 8'((HS_SWITCH_NS * CLK_MHZ + 999) / 1000);

	// ------------------------------------------------------------------
	// State codes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_POR   = 3'b001,
		ST_RESET = 3'b010,
		ST_RUN   = 3'b100
	} seq_state_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_t;

endpackage : rst_pkg

// ---- rtl/sync2.sv ----
/*
 * Two-flop level synchroniser for the shared reset pin.
 * Assumes the input is asynchronous to clk; resets to a released pin.
 */
`timescale 1ns/100ps
`default_nettype none

module sync2 (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	// First flop feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= 1'b1;
			q      <= 1'b1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : sync2

`default_nettype wire

// ---- rtl/reset_source_and_regulator_ctrl.sv ----
/*
 * Reset sequencer, reset-cause flags, shared reset pin function, reset
 * fetch vector and regulator mode control, with an Avalon-MM slave.
 * Assumes srst is the power-on reset and reset-source inputs are
 * single-cycle pulses on clk; the shared pin is asynchronous.
 */
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Power-on leaves regulators in high speed
// - Bit 7 selects low current mode
// - Ready flag: set after switch back, cleared entering
// - Only power-on resets the mode bit and ready flag
// - Pin enable one: reset input, else plain input
// - Pin is reset input during power-on sequence
// - Only power-on overrides the pin function
// - One cause flag per reset source
// - Flags sticky, cleared by writing zero
// - Power-on sets power and brownout flags only
// - Watchdog reset flags behave like power-on
// - Other resets add their flag, keep others
// - Pin low at power-on end sets pin flag
// - Break resets only when enabled, sets flag
// - Watchdog flag valid only with its config
// - Brownout interrupt flag sticky until zero written
// - Boot address is vector byte then 00h
// - Boot fetch after break, boot status, programming
// - Brownout interrupt only when enable bit set
module reset_source_and_regulator_ctrl
	import rst_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire logic [ADDR_W-1:0]    address,
	input  wire logic                 read,
	input  wire logic                 write,
	input  wire logic [31:0]          writedata,
	input  wire logic [3:0]           byteenable,
	output logic      [31:0]          readdata,
	output logic                      waitrequest,
	input  wire logic                 shared_reset_pin_n,
	input  wire logic                 bod_reset,
	input  wire logic                 wdog_timeout,
	input  wire logic                 soft_reset_req,
	input  wire logic                 break_detect,
	input  wire logic                 brownout_irq_evt,
	output logic                      sys_reset,
	output logic                      pin_is_reset,
	output logic                      pin_digital_in,
	output logic                      regulator_low_current,
	output logic      [15:0]          fetch_addr
);
	import rst_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	seq_state_t state_q;
	bus_state_t bus_q;
	logic [7:0] cnt_q;
	logic [7:0] cause_q;
	logic [7:0] cause_d;
	logic [7:0] cfg_q;
	logic [7:0] bootvec_q;
	logic       low_cur_q;
	logic       hs_ready_q;
	logic [7:0] sw_cnt_q;
	logic       brk_cause_q;
	logic [15:0] fetch_q;
	logic [31:0] rdata_q;
	logic       pin_gpio_q;
	logic       pin_n_s;
	logic       acc;
	logic       wr_en;
	logic       wr_cause;
	logic       wr_mode;
	logic       ext_evt;
	logic       bk_evt;
	logic       wd_evt;
	logic       any_evt;
	logic       boot_sel;
	logic       reset_pin_function_enable;

	function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a,
			input logic [7:0] cause, input logic [7:0] mode,
			input logic [7:0] cfg, input logic [7:0] bv, input logic [7:0] st);
		case (a)
			ADR_CAUSE:   read_mux = cause & CAUSE_MASK;
			ADR_REGMODE: read_mux = mode;
			ADR_CFG:     read_mux = cfg & CFG_MASK;
			ADR_BOOTVEC: read_mux = bv;
			ADR_STATUS:  read_mux = st;
			default:     read_mux = 8'h00;
		endcase
	endfunction : read_mux

	sync2 u_pin_sync (
		.clk  (clk),
		.srst (srst),
		.d    (shared_reset_pin_n),
		.q    (pin_n_s)
	);

	// ------------------------------------------------------------------
	// Avalon-MM slave: one wait state per access
	// ------------------------------------------------------------------
	assign acc         = read | write;
	assign waitrequest = acc & (bus_q == BUS_IDLE);
	assign wr_en       = write & (bus_q == BUS_ACK) & byteenable[0];
	assign wr_cause    = wr_en & (address == ADR_CAUSE);
	assign wr_mode     = wr_en & (address == ADR_REGMODE);
	assign readdata    = rdata_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			bus_q <= BUS_IDLE;
		end else begin
			case (bus_q)
				BUS_IDLE: bus_q <= acc ? BUS_ACK : BUS_IDLE;
				BUS_ACK:  bus_q <= BUS_IDLE;
				default:  bus_q <= BUS_IDLE;
			endcase
		end
	end

	// Unused upper bits and unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 32'h0000_0000;
		end else if (read && bus_q == BUS_IDLE) begin
			rdata_q <= {24'h00_0000, read_mux(address, cause_q,
				{low_cur_q, 6'h00, hs_ready_q}, cfg_q, bootvec_q,
				{4'h0, boot_sel, pin_n_s, pin_is_reset, sys_reset})};
		end
	end

	// ------------------------------------------------------------------
	// Configuration bytes, bus-writable, reset by power-on only
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_q     <= CFG_RST;
			bootvec_q <= BOOTVEC_RST;
		end else if (wr_en && address == ADR_CFG) begin
			cfg_q <= writedata[7:0] & CFG_MASK;
		end else if (wr_en && address == ADR_BOOTVEC) begin
			bootvec_q <= writedata[7:0];
		end
	end

	assign reset_pin_function_enable = cfg_q[CFG_RPE_BIT];

	// ------------------------------------------------------------------
	// Shared pin function
	// ------------------------------------------------------------------
	// Power-on forces reset function; later resets keep config
	assign pin_is_reset = (state_q == ST_POR) | reset_pin_function_enable;
	assign pin_digital_in = pin_gpio_q;

	// Pin reads high while owned by the reset function
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_gpio_q <= 1'b1;
		end else begin
			pin_gpio_q <= pin_is_reset ? 1'b1 : pin_n_s;
		end
	end

	// ------------------------------------------------------------------
	// Reset sequencer
	// ------------------------------------------------------------------
	assign ext_evt = reset_pin_function_enable & ~pin_n_s;
	assign bk_evt  = break_detect & cfg_q[CFG_BRK_BIT];
	assign wd_evt  = wdog_timeout;
	assign any_evt = ext_evt | bk_evt | wd_evt | bod_reset | soft_reset_req;
	assign sys_reset = (state_q != ST_RUN);

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= ST_POR;
			cnt_q   <= POR_CYC;
		end else begin
			case (state_q)
				ST_POR: begin
					if (cnt_q > 8'h01) begin
						cnt_q <= cnt_q - 8'h01;
					end else begin
						// A pin still low keeps the part in reset
						state_q <= ext_evt ? ST_RESET : ST_RUN;
						cnt_q   <= 8'h00;
					end
				end
				ST_RESET: begin
					if (any_evt) begin
						cnt_q <= PULSE_CYC;
					end else if (cnt_q != 8'h00) begin
						cnt_q <= cnt_q - 8'h01;
					end else begin
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (any_evt) begin
						state_q <= ST_RESET;
						cnt_q   <= PULSE_CYC;
					end
				end
				default: begin
					state_q <= ST_POR;
					cnt_q   <= POR_CYC;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Reset-cause flags
	// ------------------------------------------------------------------
	always_comb begin
		cause_d = cause_q;
		if (wr_cause) begin
			cause_d = cause_q & writedata[7:0];
		end
		if (state_q == ST_POR && cnt_q <= 8'h01 && !pin_n_s) begin
			cause_d[EX_BIT] = 1'b1;
		end
		if (state_q != ST_POR) begin
			// Events win over a clearing write in the same cycle
			if (ext_evt) cause_d[EX_BIT] = 1'b1;
			if (soft_reset_req) cause_d[SF_BIT] = 1'b1;
			if (bk_evt) cause_d[BK_BIT] = 1'b1;
			if (bod_reset) cause_d[BOF_BIT] = 1'b1;
			if (brownout_irq_evt && cfg_q[CFG_BOI_BIT]) begin
				cause_d[BROWNOUT_IRQ_FLAG_BIT] = 1'b1;
			end
			if (wd_evt) begin
				// Same pattern as power-on; watchdog flag only if configured
				cause_d = CAUSE_POR | {1'b0, cause_d[BROWNOUT_IRQ_FLAG_BIT], 6'h00} |
					{5'h00, cfg_q[CFG_WD_BIT], 2'b00};
			end
		end
		cause_d = cause_d & CAUSE_MASK;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cause_q <= CAUSE_POR;
		end else begin
			cause_q <= cause_d;
		end
	end

	// ------------------------------------------------------------------
	// Reset fetch vector
	// ------------------------------------------------------------------
	assign boot_sel = brk_cause_q | cfg_q[CFG_BOOT_BIT] | cfg_q[CFG_ISP_BIT];
	assign fetch_addr = fetch_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			brk_cause_q <= 1'b0;
		end else if (bk_evt && state_q != ST_POR) begin
			brk_cause_q <= 1'b1;
		end else if (state_q == ST_RUN) begin
			brk_cause_q <= 1'b0;
		end
	end

	// Latched as the core leaves reset
	always_ff @(posedge clk) begin
		if (srst) begin
			fetch_q <= RESET_VECTOR;
		end else if ((state_q == ST_POR && cnt_q <= 8'h01 && !ext_evt) ||
				(state_q == ST_RESET && cnt_q == 8'h00 && !any_evt)) begin
			fetch_q <= boot_sel ? {bootvec_q, BOOT_LOW} : RESET_VECTOR;
		end
	end

	// ------------------------------------------------------------------
	// Regulator mode; software keeps clock in range first
	// ------------------------------------------------------------------
	assign regulator_low_current = low_cur_q;

	// Kept across non-power-on resets so the ready flag stays put
	always_ff @(posedge clk) begin
		if (srst) begin
			low_cur_q  <= 1'b0;
			hs_ready_q <= 1'b1;
			sw_cnt_q   <= 8'h00;
		end else if (wr_mode) begin
			low_cur_q <= writedata[LOW_CUR_BIT];
			if (writedata[LOW_CUR_BIT]) begin
				hs_ready_q <= 1'b0;
				sw_cnt_q   <= 8'h00;
			end else if (low_cur_q) begin
				sw_cnt_q <= HS_CYC;
			end
		end else if (sw_cnt_q != 8'h00) begin
			sw_cnt_q <= sw_cnt_q - 8'h01;
			if (sw_cnt_q == 8'h01) begin
				hs_ready_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_switch_back;
		!hs_ready_q ##[1:60] hs_ready_q;
	endsequence

	sequence s_por_release;
		!srst && $past(srst);
	endsequence

	property p_por_defaults;
		@(posedge clk) disable iff (srst)
		s_por_release |-> hs_ready_q && !low_cur_q && cause_q == CAUSE_POR &&
			state_q == ST_POR;
	endproperty
	a_por_defaults: assert property (p_por_defaults) else $error("power-on defaults wrong");

	property p_enter_low;
		@(posedge clk) disable iff (srst)
		wr_mode && writedata[LOW_CUR_BIT] |=> low_cur_q && !hs_ready_q;
	endproperty
	a_enter_low: assert property (p_enter_low) else $error("low current entry wrong");

	property p_switch_back;
		@(posedge clk) disable iff (srst)
		wr_mode && !writedata[LOW_CUR_BIT] && low_cur_q |=> s_switch_back;
	endproperty
	a_switch_back: assert property (p_switch_back) else $error("ready flag did not return");

	property p_ready_cause;
		@(posedge clk) disable iff (srst)
		$rose(hs_ready_q) |-> $past(sw_cnt_q) == 8'h01 && !low_cur_q;
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready flag set without switch");

	property p_pin_function;
		@(posedge clk) disable iff (srst)
		pin_is_reset == (state_q == ST_POR || cfg_q[CFG_RPE_BIT]);
	endproperty
	a_pin_function: assert property (p_pin_function) else $error("pin function wrong");

	property p_pin_reset;
		@(posedge clk) disable iff (srst)
		state_q == ST_RUN && reset_pin_function_enable && !pin_n_s && !wd_evt |=> sys_reset && cause_q[EX_BIT];
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset not taken");

	property p_por_pin_low;
		@(posedge clk) disable iff (srst)
		state_q == ST_POR && cnt_q == 8'h01 && !pin_n_s |=> cause_q[EX_BIT];
	endproperty
	a_por_pin_low: assert property (p_por_pin_low) else $error("pin flag missing after power-on");

	property p_sticky_soft;
		@(posedge clk) disable iff (srst)
		cause_q[SF_BIT] && !wr_cause && !wd_evt |=> cause_q[SF_BIT];
	endproperty
	a_sticky_soft: assert property (p_sticky_soft) else $error("soft flag lost");

	property p_soft_sets;
		@(posedge clk) disable iff (srst)
		soft_reset_req && !wd_evt && state_q != ST_POR |=> cause_q[SF_BIT] && sys_reset;
	endproperty
	a_soft_sets: assert property (p_soft_sets) else $error("soft reset not recorded");

	property p_wdog;
		@(posedge clk) disable iff (srst)
		wd_evt && state_q != ST_POR |=> cause_q[5:0] == ({2'b11, 4'h0} |
			{3'b000, $past(cfg_q[CFG_WD_BIT]), 2'b00});
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog flags wrong");

	property p_break;
		@(posedge clk) disable iff (srst)
		state_q == ST_RUN && break_detect && cfg_q[CFG_BRK_BIT] && !wd_evt |=>
			cause_q[BK_BIT] && sys_reset;
	endproperty
	a_break: assert property (p_break) else $error("break reset wrong");

	property p_break_off;
		@(posedge clk) disable iff (srst)
		state_q == ST_RUN && break_detect && !cfg_q[CFG_BRK_BIT] && !any_evt |=> !sys_reset;
	endproperty
	a_break_off: assert property (p_break_off) else $error("break reset while disabled");

	property p_brownout_irq_flag;
		@(posedge clk) disable iff (srst)
		state_q != ST_POR && brownout_irq_evt && !wd_evt |=>
			cause_q[BROWNOUT_IRQ_FLAG_BIT] == ($past(cfg_q[CFG_BOI_BIT]) ||
			($past(cause_q[BROWNOUT_IRQ_FLAG_BIT]) && !($past(wr_cause) && !$past(writedata[BROWNOUT_IRQ_FLAG_BIT]))));
	endproperty
	a_brownout_irq_flag: assert property (p_brownout_irq_flag) else $error("brownout interrupt flag wrong");

	property p_fetch;
		@(posedge clk) disable iff (srst)
		$fell(sys_reset) |-> fetch_q ==
			($past(boot_sel) ? {$past(bootvec_q), BOOT_LOW} : RESET_VECTOR);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address wrong");

	property p_reserved;
		@(posedge clk) disable iff (srst)
		!cause_q[7] && readdata[31:8] == 24'h00_0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	property p_bus_wait;
		@(posedge clk) disable iff (srst)
		acc && bus_q == BUS_IDLE |-> waitrequest ##1 !waitrequest;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("bus wait state wrong");

endmodule : reset_source_and_regulator_ctrl

`default_nettype wire

// ---- tb/reset_source_and_regulator_ctrl_test.sv ----
/*
 * Self-checking bench for the reset-cause and regulator-mode block.
 * Assumes the bench is the only Avalon-MM master and drives every
 * reset-source pulse and the shared pin itself.
 */
`timescale 1ns/100ps
`default_nettype none

module reset_source_and_regulator_ctrl_test;
	import rst_pkg::*;

	// ------------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------------
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic [ADDR_W-1:0] address = '0;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [31:0]       writedata = '0;
	logic [3:0]        byteenable = 4'hf;
	logic [31:0]       readdata;
	logic              waitrequest;
	logic              pin_n = 1'b1;
	logic [4:0]        evt = '0;
	logic              sys_reset;
	logic              pin_is_reset;
	logic              pin_digital_in;
	logic              regulator_low_current;
	logic [15:0]       fetch_addr;
	logic [31:0]       rd;
	int                n_errors = 0;
	int                comparisons = 0;
	localparam logic [ADDR_W-1:0] ADR_NONE = {8'h40, 2'b00};

	always #5 clk = ~clk;

	reset_source_and_regulator_ctrl i_dut (
		.clk                   (clk),
		.srst                  (srst),
		.address               (address),
		.read                  (read),
		.write                 (write),
		.writedata             (writedata),
		.byteenable            (byteenable),
		.readdata              (readdata),
		.waitrequest           (waitrequest),
		.shared_reset_pin_n    (pin_n),
		.bod_reset             (evt[0]),
		.wdog_timeout          (evt[1]),
		.soft_reset_req        (evt[2]),
		.break_detect          (evt[3]),
		.brownout_irq_evt      (evt[4]),
		.sys_reset             (sys_reset),
		.pin_is_reset          (pin_is_reset),
		.pin_digital_in        (pin_digital_in),
		.regulator_low_current (regulator_low_current),
		.fetch_addr            (fetch_addr)
	);

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Read right after the edge: the values the slave showed at that edge
	task automatic wait_ack(output logic [31:0] data);
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) begin
				data = readdata;
				read  <= 1'b0;
				write <= 1'b0;
				@(negedge clk);
				return;
			end
		end
		n_errors++;
		end_sim();
	endtask : wait_ack

	task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [31:0] unused;
		@(posedge clk);
		address   <= a;
		writedata <= {24'h0, d};
		write     <= 1'b1;
		wait_ack(unused);
	endtask : bus_write

	task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge clk);
		address <= a;
		read    <= 1'b1;
		wait_ack(d);
	endtask : bus_read

	task automatic read_check(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		bus_read(a, rd);
		check(rd, {24'h0, exp});
	endtask : read_check

	task automatic pulse(input int unsigned which);
		@(posedge clk);
		evt[which] <= 1'b1;
		@(posedge clk);
		evt[which] <= 1'b0;
		@(negedge clk);
	endtask : pulse

	task automatic wait_run;
		for (int i = 0; i < 1000; i++) begin
			@(negedge clk);
			if (sys_reset === 1'b0)
				return;
		end
		n_errors++;
		end_sim();
	endtask : wait_run

	task automatic por;
		@(posedge clk);
		srst <= 1'b1;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
	endtask : por

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_values;
		@(negedge clk);
		check(pin_is_reset, 1'b1);
		wait_run();
		check(regulator_low_current, 1'b0);
		check(fetch_addr, RESET_VECTOR);
		read_check(ADR_CAUSE, 8'h30);
		read_check(ADR_REGMODE, 8'h01);
		read_check(ADR_CFG, CFG_RST);
		@(posedge clk);
		byteenable <= 4'he;
		bus_write(ADR_BOOTVEC, 8'h00);
		@(posedge clk);
		byteenable <= 4'hf;
		read_check(ADR_BOOTVEC, BOOTVEC_RST);
		read_check(ADR_STATUS, 8'h06);
		bus_write(ADR_NONE, 8'hff);
		read_check(ADR_NONE, 8'h00);
		$display("test reset_values done");
	endtask : t_reset_values

	task automatic t_regulator;
		bus_write(ADR_REGMODE, 8'hff);
		check(regulator_low_current, 1'b1);
		read_check(ADR_REGMODE, 8'h80);
		pulse(2);
		check(sys_reset, 1'b1);
		wait_run();
		read_check(ADR_REGMODE, 8'h80);
		bus_write(ADR_REGMODE, 8'h00);
		check(regulator_low_current, 1'b0);
		rd = '0;
		for (int i = 0; i < 100 && rd[HS_READY_BIT] !== 1'b1; i++)
			bus_read(ADR_REGMODE, rd);
		check(rd, 32'h01);
		if (rd !== 32'h01)
			end_sim();
		$display("test regulator done");
	endtask : t_regulator

	task automatic t_sticky;
		read_check(ADR_CAUSE, 8'h32);
		bus_write(ADR_CAUSE, 8'hff);
		read_check(ADR_CAUSE, 8'h32);
		bus_write(ADR_CAUSE, 8'hfd);
		read_check(ADR_CAUSE, 8'h30);
		bus_write(ADR_CAUSE, 8'h00);
		read_check(ADR_CAUSE, 8'h00);
		pulse(0);
		wait_run();
		read_check(ADR_CAUSE, 8'h20);
		$display("test sticky done");
	endtask : t_sticky

	task automatic t_break_boot;
		bus_write(ADR_BOOTVEC, 8'h5a);
		pulse(3);
		check(sys_reset, 1'b0);
		read_check(ADR_CAUSE, 8'h20);
		bus_write(ADR_CFG, 8'h03);
		pulse(3);
		check(sys_reset, 1'b1);
		wait_run();
		check(fetch_addr, {8'h5a, BOOT_LOW});
		read_check(ADR_CAUSE, 8'h28);
		bus_write(ADR_CFG, 8'h01);
		pulse(2);
		wait_run();
		check(fetch_addr, RESET_VECTOR);
		for (int k = 0; k < 2; k++) begin
			bus_write(ADR_CFG, k == 0 ? 8'h11 : 8'h21);
			pulse(2);
			wait_run();
			check(fetch_addr, 16'h5a00);
		end
		bus_write(ADR_CFG, 8'h01);
		$display("test break_boot done");
	endtask : t_break_boot

	task automatic t_watchdog;
		bus_write(ADR_CAUSE, 8'h00);
		pulse(4);
		read_check(ADR_CAUSE, 8'h00);
		bus_write(ADR_CFG, 8'h09);
		pulse(4);
		read_check(ADR_CAUSE, 8'h40);
		pulse(2);
		wait_run();
		bus_write(ADR_CFG, 8'h0d);
		pulse(1);
		check(sys_reset, 1'b1);
		wait_run();
		read_check(ADR_CAUSE, 8'h74);
		bus_write(ADR_CFG, 8'h01);
		$display("test watchdog done");
	endtask : t_watchdog

	task automatic t_pin;
		bus_write(ADR_CFG, 8'h00);
		pulse(2);
		check(pin_is_reset, 1'b0);
		wait_run();
		bus_write(ADR_CAUSE, 8'h00);
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (6) @(negedge clk);
		check(pin_digital_in, 1'b0);
		check(pin_is_reset, 1'b0);
		check(sys_reset, 1'b0);
		@(posedge clk);
		pin_n <= 1'b1;
		bus_write(ADR_CFG, 8'h01);
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (6) @(negedge clk);
		check(sys_reset, 1'b1);
		check(pin_digital_in, 1'b1);
		@(posedge clk);
		pin_n <= 1'b1;
		wait_run();
		read_check(ADR_CAUSE, 8'h01);
		$display("test pin done");
	endtask : t_pin

	task automatic t_por_pin_low;
		bus_write(ADR_CFG, 8'h00);
		bus_write(ADR_REGMODE, 8'h80);
		@(posedge clk);
		pin_n <= 1'b0;
		por();
		repeat (3) @(negedge clk);
		check(pin_is_reset, 1'b1);
		repeat (150) @(negedge clk);
		check(sys_reset, 1'b1);
		@(posedge clk);
		pin_n <= 1'b1;
		wait_run();
		read_check(ADR_CAUSE, 8'h31);
		read_check(ADR_REGMODE, 8'h01);
		$display("test por_pin_low done");
	endtask : t_por_pin_low

	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_reset_values();
		t_regulator();
		t_sticky();
		t_break_boot();
		t_watchdog();
		t_pin();
		t_por_pin_low();
		end_sim();
	end

endmodule : reset_source_and_regulator_ctrl_test

`default_nettype wire
